// File: hw/ebm_master.sv
// bus master: request, grant, cycle start, completion and release of the expansion bus
`timescale 1ns/1ps
module ebm_master
    import ebm_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        cfgIsa,
    input  wire logic        cfgWide16,
    input  wire logic        bclk,
    input  wire logic        grant_n,
    input  wire logic        dak2_n,
    input  wire logic        slaveRdy,
    input  wire logic        ack16_n,
    input  wire logic        ack32_n,
    input  wire logic [31:0] dataIn,
    output logic             request_n,
    output logic             master16_n,
    output logic             master16Oe,
    output logic [31:2]      addrOut,
    output logic [3:0]       byteEn_n,
    output logic             burst_n,
    output logic             lock_n,
    output logic             start_n,
    output logic             memIo,
    output logic             writeRead,
    output logic             ctlOe,
    output logic [31:0]      dataOut,
    output logic             dataOe,
    input  wire logic        xferValid,
    output logic             xferReady,
    input  wire logic [31:2] xferAddr,
    input  wire logic [3:0]  xferBe,
    input  wire logic        xferWrite,
    input  wire logic        xferMem,
    input  wire logic [31:0] xferWdata,
    input  wire logic        xferLast,
    input  wire logic        xferBurst,
    input  wire logic        xferLock,
    input  wire logic        xferSize16,
    output logic             doneValid,
    output logic [31:0]      doneRdata
);
    ebm_sync_if sy ();

    logic [31:0] dataMeta_r;
    logic [31:0] dataSync_r;

    ebm_sync u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pinsRaw ({ack32_n, ack16_n, slaveRdy, dak2_n, grant_n, bclk}),
        .sy      (sy)
    );

    ebm_state_e  state_r,    state_nxt;
    ebm_bus_s    bus_r,      bus_nxt;
    logic        inBurst_r,  inBurst_nxt;
    logic        lastDone_r, lastDone_nxt;
    logic        lastCyc_r,  lastCyc_nxt;
    logic [1:0]  gapCnt_r,   gapCnt_nxt;
    logic [6:0]  lossCnt_r,  lossCnt_nxt;
    logic        done_r,     done_nxt;
    logic [31:0] rdata_r,    rdata_nxt;
    logic        granted;
    logic        cycEnd;
    logic        take;
    logic        relIdle;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dataMeta_r <= '0;
            dataSync_r <= '0;
        end else begin
            dataMeta_r <= dataIn;
            dataSync_r <= dataMeta_r;
        end
    end

    assign granted = cfgIsa ? ~sy.lvl[PIN_DAK2_N] : ~sy.lvl[PIN_GRANT_N];
    assign cycEnd  = sy.rise & (sy.lvl[PIN_RDY] | ~sy.lvl[PIN_ACK16_N] | ~sy.lvl[PIN_ACK32_N]);
    assign relIdle = ~granted | (lastDone_r & ~xferValid);
    assign take    = (state_r == EBM_OWN) & sy.fall & ~relIdle & xferValid;

    always_comb begin
        state_nxt    = state_r;
        bus_nxt      = bus_r;
        inBurst_nxt  = inBurst_r;
        lastDone_nxt = lastDone_r;
        lastCyc_nxt  = lastCyc_r;
        gapCnt_nxt   = gapCnt_r;
        done_nxt     = 1'b0;
        rdata_nxt    = rdata_r;
        // waiting for a first grant is not a grant loss, so the request phase does not count
        lossCnt_nxt  = (granted || state_r == EBM_IDLE || state_r == EBM_REQ || state_r == EBM_GAP) ? 7'h00
                     : lossCnt_r + {6'h00, sy.rise};
        case (state_r)
            EBM_IDLE: begin
                if (xferValid) begin
                    bus_nxt.req  = 1'b1;
                    lastDone_nxt = 1'b0;
                    inBurst_nxt  = 1'b0;
                    state_nxt    = EBM_REQ;
                end
            end
            EBM_REQ: begin
                // request stays up until grant is sampled on a rise
                if (sy.rise && granted) begin
                    bus_nxt.m16 = cfgWide16;
                    state_nxt   = EBM_OWN;
                end
            end
            EBM_OWN: begin
                if (sy.fall && relIdle) begin
                    // idle release: everything floats before the next rise
                    bus_nxt       = BUS_RESET;
                    gapCnt_nxt    = 2'h0;
                    state_nxt     = EBM_GAP;
                end else if (take) begin
                    // drive on the falling edge after the grant rise
                    bus_nxt.ctlOe  = 1'b1;
                    bus_nxt.dataOe = xferWrite;
                    bus_nxt.addr   = xferAddr;
                    bus_nxt.be     = xferBe;
                    bus_nxt.mem    = xferMem;
                    bus_nxt.write  = xferWrite;
                    bus_nxt.wdata  = xferWdata;
                    bus_nxt.lock   = xferLock;
                    bus_nxt.burst  = xferBurst & inBurst_r;
                    bus_nxt.start  = 1'b1;
                    bus_nxt.m16    = cfgWide16 | xferSize16;
                    lastCyc_nxt    = xferLast;
                    inBurst_nxt    = xferBurst & ~xferLast;
                    state_nxt      = EBM_STRT;
                end
            end
            EBM_STRT: begin
                if (sy.rise) begin
                    bus_nxt.start = 1'b0;
                    state_nxt     = EBM_WAIT;
                end
            end
            EBM_WAIT: begin
                if (cycEnd || lossCnt_r >= GRANT_LOSS_FORCE) begin
                    done_nxt  = cycEnd;
                    rdata_nxt = dataSync_r;
                    if (lastCyc_r) begin
                        bus_nxt.m16  = 1'b0;
                        lastDone_nxt = 1'b1;
                    end
                    if (lastCyc_r || !granted) begin
                        // control floats at the ending rise, data waits for the fall
                        bus_nxt.ctlOe = 1'b0;
                        bus_nxt.burst = 1'b0;
                        bus_nxt.lock  = 1'b0;
                        state_nxt     = EBM_RELS;
                    end else begin
                        state_nxt = EBM_OWN;
                    end
                end
            end
            EBM_RELS: begin
                if (sy.fall) begin
                    bus_nxt    = BUS_RESET;
                    gapCnt_nxt = 2'h0;
                    state_nxt  = EBM_GAP;
                end
            end
            EBM_GAP: begin
                // release sits on a fall, so two more falls make two whole bus clocks
                if (sy.fall) begin
                    gapCnt_nxt = gapCnt_r + 2'h1;
                end
                if (gapCnt_r == REL_GAP_BCLK) begin
                    state_nxt = EBM_IDLE;
                end
            end
            default: begin
                bus_nxt   = BUS_RESET;
                state_nxt = EBM_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r    <= EBM_IDLE;
            bus_r      <= BUS_RESET;
            inBurst_r  <= 1'b0;
            lastDone_r <= 1'b0;
            lastCyc_r  <= 1'b0;
            gapCnt_r   <= 2'h0;
            lossCnt_r  <= 7'h00;
            done_r     <= 1'b0;
            rdata_r    <= '0;
        end else begin
            state_r    <= state_nxt;
            bus_r      <= bus_nxt;
            inBurst_r  <= inBurst_nxt;
            lastDone_r <= lastDone_nxt;
            lastCyc_r  <= lastCyc_nxt;
            gapCnt_r   <= gapCnt_nxt;
            lossCnt_r  <= lossCnt_nxt;
            done_r     <= done_nxt;
            rdata_r    <= rdata_nxt;
        end
    end

    // isa mode drops the size line the moment acknowledge goes, not a cycle later
    logic m16Active;
    assign m16Active  = bus_r.m16 & ~(cfgIsa & sy.lvl[PIN_DAK2_N]);
    assign request_n  = ~bus_r.req;
    assign master16_n = ~m16Active;
    assign master16Oe = m16Active;
    assign addrOut    = bus_r.addr;
    assign byteEn_n   = ~bus_r.be;
    assign burst_n    = ~bus_r.burst;
    assign lock_n     = ~bus_r.lock;
    assign start_n    = ~bus_r.start;
    assign memIo      = bus_r.mem;
    assign writeRead  = bus_r.write;
    assign ctlOe      = bus_r.ctlOe;
    assign dataOut    = bus_r.wdata;
    assign dataOe     = bus_r.dataOe;
    assign xferReady  = take;
    assign doneValid  = done_r;
    assign doneRdata  = rdata_r;

    // helper: bus clock falls since the request was last dropped
    logic [1:0] relFall_r;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            relFall_r <= 2'h3;
        end else if (bus_r.req) begin
            relFall_r <= 2'h0;
        end else if (sy.fall && relFall_r != 2'h3) begin
            relFall_r <= relFall_r + 2'h1;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence sEndLast;
        state_r == EBM_WAIT && cycEnd && lastCyc_r;
    endsequence
    sequence sFloatCtl;
        !ctlOe ##0 (state_r == EBM_RELS);
    endsequence

    a_req_held: assert property (state_r == EBM_REQ && !(sy.rise && granted) |=> !request_n)
        else $error("request dropped before grant");
    a_m16_after_grant: assert property ($fell(master16_n) |-> granted)
        else $error("size indication without grant");
    a_m16_last_drop: assert property (sEndLast |=> master16_n)
        else $error("size indication kept after final transfer");
    a_isa_dak_drop: assert property (cfgIsa && sy.lvl[PIN_DAK2_N] |-> master16_n)
        else $error("isa size indication outlived acknowledge");
    a_drive_on_fall: assert property ($rose(ctlOe) |-> $past(sy.fall) && $past(granted))
        else $error("drive began off a falling edge");
    a_idle_release: assert property (state_r == EBM_OWN && sy.fall && relIdle
        |=> !ctlOe && !dataOe && request_n)
        else $error("idle release left lines driven");
    a_ctl_end_float: assert property (sEndLast |=> sFloatCtl)
        else $error("control still driven after ending rise");
    a_data_late_float: assert property (state_r == EBM_RELS && sy.fall |=> !dataOe ##1 !dataOe)
        else $error("data driven past falling edge");
    a_rerequest_gap: assert property ($fell(request_n) |-> relFall_r >= REL_GAP_BCLK)
        else $error("request repeated too soon");
    a_burst_second: assert property ($rose(start_n == 1'b0) && !burst_n |-> $past(inBurst_r))
        else $error("burst on first cycle");
    a_mio_type: assert property (take |=> memIo == $past(xferMem) && !start_n)
        else $error("memory or io indication wrong");
    a_loss_bound: assert property (lossCnt_r < GRANT_LOSS_MAX)
        else $error("bus held too long after grant loss");
    a_float_unowned: assert property (state_r inside {EBM_IDLE, EBM_REQ, EBM_GAP} |-> !ctlOe && !dataOe)
        else $error("lines driven without owning bus");
endmodule

// File: hw/ebm_pkg.sv
// constants and types for the expansion-bus master acquire and release block
package ebm_pkg;
    localparam int unsigned REF_CLK_PERIOD_NS = 10;
    localparam logic [1:0]  REL_GAP_BCLK      = 2'h2;   // bus clocks between release and new request
    localparam logic [6:0]  GRANT_LOSS_MAX    = 7'h40;  // bus clocks allowed after grant withdrawal
    localparam logic [6:0]  GRANT_LOSS_FORCE  = 7'h38;  // abort point, leaves margin for release
    localparam int unsigned SYNC_W            = 6;
    // bit positions in the synchronised pin vector
    localparam int unsigned PIN_BCLK          = 0;
    localparam int unsigned PIN_GRANT_N       = 1;
    localparam int unsigned PIN_DAK2_N        = 2;
    localparam int unsigned PIN_RDY           = 3;
    localparam int unsigned PIN_ACK16_N       = 4;
    localparam int unsigned PIN_ACK32_N       = 5;

    typedef enum logic [2:0] {
        EBM_IDLE = 3'h0,
        EBM_REQ  = 3'h1,
        EBM_OWN  = 3'h3,
        EBM_STRT = 3'h2,
        EBM_WAIT = 3'h6,
        EBM_RELS = 3'h7,
        EBM_GAP  = 3'h5
    } ebm_state_e;

    typedef struct packed {
        logic        req;
        logic        m16;
        logic        ctlOe;
        logic        dataOe;
        logic [29:0] addr;
        logic [3:0]  be;
        logic        burst;
        logic        lock;
        logic        start;
        logic        mem;
        logic        write;
        logic [31:0] wdata;
    } ebm_bus_s;

    localparam ebm_bus_s BUS_RESET = '{default: '0};
endpackage

// File: hw/ebm_sync_if.sv
// synchronised bus pins and bus clock edge events
`timescale 1ns/1ps
interface ebm_sync_if;
    import ebm_pkg::*;
    logic [SYNC_W-1:0] lvl;
    logic              rise;
    logic              fall;
    modport src (output lvl, output rise, output fall);
    modport dst (input  lvl, input  rise, input  fall);
endinterface

// File: hw/ebm_sync.sv
// two-flop synchroniser for the bus pins with bus clock edge detection
`timescale 1ns/1ps
module ebm_sync
    import ebm_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic [SYNC_W-1:0] pinsRaw,
    ebm_sync_if.src                sy
);
    logic [SYNC_W-1:0] meta_r;
    logic [SYNC_W-1:0] stab_r;
    logic              bclkOld_r;

    // idle pin levels: active-low pins rest high
    localparam logic [SYNC_W-1:0] PIN_IDLE = 6'h36;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            meta_r    <= PIN_IDLE;
            stab_r    <= PIN_IDLE;
            bclkOld_r <= 1'b0;
        end else begin
            meta_r    <= pinsRaw;
            stab_r    <= meta_r;
            bclkOld_r <= stab_r[PIN_BCLK];
        end
    end

    // edges come from the second and third flops, never the first
    assign sy.lvl  = stab_r;
    assign sy.rise = stab_r[PIN_BCLK] & ~bclkOld_r;
    assign sy.fall = ~stab_r[PIN_BCLK] & bclkOld_r;
endmodule

// File: dv/ebm_bus_partner.sv
// bus partner model: arbiter for slot grant and channel-2 acknowledge, plus one slave
`timescale 1ns/1ps
module ebm_bus_partner (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        isaMode,
    input  wire logic        preempt,
    input  wire logic [1:0]  termSel,
    input  wire logic [3:0]  waitCnt,
    input  wire logic        request_n,
    input  wire logic        start_n,
    input  wire logic [31:2] addrOut,
    output logic             bclk,
    output logic             grant_n,
    output logic             dak2_n,
    output logic             slaveRdy,
    output logic             ack16_n,
    output logic             ack32_n,
    output logic [31:0]      dataIn
);
    logic        gnt;
    logic        busy;
    logic        term;
    logic [3:0]  waitLeft;
    logic [31:0] rdat;
    // bus clock runs free, 120 ns period, unrelated to ref_clk
    initial begin
        bclk = 1'b0;
        forever #60 bclk = ~bclk;
    end
    always @(posedge bclk or posedge rst) begin
        if (rst) begin
            gnt      <= 1'b0;
            busy     <= 1'b0;
            waitLeft <= 4'h0;
            rdat     <= 32'h0;
        end else begin
            gnt <= ~request_n & ~preempt;
            if (!start_n) begin
                busy     <= 1'b1;
                waitLeft <= waitCnt;
                rdat     <= {addrOut, 2'h0} ^ 32'h5a5a0000;
            end else if (busy && term) begin
                busy <= 1'b0;
            end else if (waitLeft != 4'h0) begin
                waitLeft <= waitLeft - 4'h1;
            end
        end
    end
    // termination launched on the falling edge so it is settled at the sampling rise
    always @(negedge bclk or posedge rst) begin
        if (rst) begin
            term <= 1'b0;
        end else begin
            term <= busy & (waitLeft == 4'h0) & ~term;
        end
    end
    // size responses ignore memIo entirely
    assign slaveRdy = term & (termSel == 2'h0);
    assign ack16_n  = ~(term & (termSel == 2'h1));
    assign ack32_n  = ~(term & termSel[1]);
    assign grant_n  = isaMode | ~gnt;
    assign dak2_n   = ~isaMode | ~gnt;
    // released data lines show the inverse, never a stale copy
    assign dataIn   = term ? rdat : ~rdat;
endmodule

// File: dv/eisa_bus_master_acquire_release_tb_top.sv
// testbench: random bus master runs against the arbiter and slave model
`timescale 1ns/1ps
module eisa_bus_master_acquire_release_tb_top;
    logic        ref_clk, rst, cfgIsa, cfgWide16, bclk, grant_n, dak2_n, slaveRdy, ack16_n, ack32_n;
    logic        request_n, master16_n, master16Oe, burst_n, lock_n, start_n, memIo, writeRead, ctlOe, dataOe;
    logic        xferValid, xferReady, xferWrite, xferMem, xferLast, xferBurst, xferLock, xferSize16, doneValid;
    logic        preempt, expBurst;
    logic [31:2] addrOut, xferAddr;
    logic [3:0]  byteEn_n, xferBe, waitCnt;
    logic [1:0]  termSel;
    logic [31:0] dataIn, dataOut, xferWdata, doneRdata, st, r;
    int          err_count = 0, num_checks = 0, gap = 100, len;

    ebm_master DUT (.ref_clk(ref_clk), .rst(rst), .cfgIsa(cfgIsa), .cfgWide16(cfgWide16), .bclk(bclk),
        .grant_n(grant_n), .dak2_n(dak2_n), .slaveRdy(slaveRdy), .ack16_n(ack16_n), .ack32_n(ack32_n),
        .dataIn(dataIn), .request_n(request_n), .master16_n(master16_n), .master16Oe(master16Oe),
        .addrOut(addrOut), .byteEn_n(byteEn_n), .burst_n(burst_n), .lock_n(lock_n), .start_n(start_n),
        .memIo(memIo), .writeRead(writeRead), .ctlOe(ctlOe), .dataOut(dataOut), .dataOe(dataOe),
        .xferValid(xferValid), .xferReady(xferReady), .xferAddr(xferAddr), .xferBe(xferBe),
        .xferWrite(xferWrite), .xferMem(xferMem), .xferWdata(xferWdata), .xferLast(xferLast),
        .xferBurst(xferBurst), .xferLock(xferLock), .xferSize16(xferSize16), .doneValid(doneValid),
        .doneRdata(doneRdata));
    ebm_bus_partner u_partner (.ref_clk(ref_clk), .rst(rst), .isaMode(cfgIsa), .preempt(preempt),
        .termSel(termSel), .waitCnt(waitCnt), .request_n(request_n), .start_n(start_n), .addrOut(addrOut),
        .bclk(bclk), .grant_n(grant_n), .dak2_n(dak2_n), .slaveRdy(slaveRdy), .ack16_n(ack16_n),
        .ack32_n(ack32_n), .dataIn(dataIn));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] rnd();
        st = st ^ (st << 13);
        st = st ^ (st >> 17);
        st = st ^ (st << 5);
        return st;
    endfunction
    function automatic logic [31:0] exp_rdata(input logic [31:2] a);
        return {a, 2'h0} ^ 32'h5a5a0000;
    endfunction
    function automatic logic pick(input int w);
        case (w)
            0: return xferReady;
            1: return doneValid;
            2: return request_n;
            default: return dak2_n;
        endcase
    endfunction

    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (exp !== got) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_hi(input int w, input int lim);
        int n;
        n = 0;
        while (pick(w) !== 1'b1) begin
            @(posedge ref_clk);
            #1;
            n++;
            if (n > lim) begin
                chk("wait bound", 32'h1, 32'h0);
                give_verdict();
            end
        end
    endtask
    task automatic xfer(input logic first, input logic last, input logic brst, input logic s16);
        // own random word, so the run's word in r stays the same for every transfer of a run
        logic [31:0] rx;
        rx         = rnd();
        xferAddr   = rx[31:2];
        xferMem    = rx[12];
        xferWrite  = rx[13];
        xferLock   = rx[14];
        xferBe     = rx[7:4] | 4'h1;
        xferWdata  = ~rx;
        xferLast   = last;
        xferBurst  = brst;
        xferSize16 = s16;
        expBurst   = brst & ~first;
        termSel    = rx[9:8];
        waitCnt    = {2'h0, rx[11:10]};
        xferValid  = 1'b1;
        wait_hi(0, 2000);
        @(posedge ref_clk);
        #1;
        xferValid = 1'b0;
        wait_hi(1, 2000);
        if (!xferWrite) chk("doneRdata", exp_rdata(xferAddr), doneRdata);
        if (last) begin
            repeat (3) @(posedge ref_clk);
            #1;
            chk("master16_n after last", 32'h1, {31'h0, master16_n});
            chk("ctlOe after last", 32'h0, {31'h0, ctlOe});
        end
    endtask

    always @(negedge start_n) begin
        #1;
        chk("addrOut", {2'h0, xferAddr}, {2'h0, addrOut});
        chk("memIo", {31'h0, xferMem}, {31'h0, memIo});
        chk("burst_n", {31'h0, ~expBurst}, {31'h0, burst_n});
        chk("master16_n", {31'h0, ~(cfgWide16 | xferSize16)}, {31'h0, master16_n});
        chk("master16Oe", {31'h0, cfgWide16 | xferSize16}, {31'h0, master16Oe});
        chk("ctlOe at start", 32'h1, {31'h0, ctlOe});
        chk("byteEn_n", {28'h0, ~xferBe}, {28'h0, byteEn_n});
        chk("lock_n", {31'h0, ~xferLock}, {31'h0, lock_n});
        chk("writeRead", {31'h0, xferWrite}, {31'h0, writeRead});
        chk("dataOe at start", {31'h0, xferWrite}, {31'h0, dataOe});
        if (xferWrite) chk("dataOut", xferWdata, dataOut);
    end
    always @(posedge request_n) begin
        #1;
        chk("ctlOe at release", 32'h0, {31'h0, ctlOe});
        chk("dataOe at release", 32'h0, {31'h0, dataOe});
        // the edge that reset makes on request_n is no release
        if (rst === 1'b0) gap = 0;
    end
    // release is on a fall, so whole bus clocks are counted fall to fall
    always @(negedge bclk) gap = gap + 1;
    always @(negedge request_n) if (rst === 1'b0) chk("gap before request", 32'h1, {31'h0, gap >= 2});
    // control lines may only be driven while the request is still up
    always @(posedge ref_clk) begin
        if (rst === 1'b0 && ctlOe === 1'b1 && request_n !== 1'b0) begin
            chk("ctlOe owner", 32'h0, 32'h1);
        end
    end

    initial begin
        st = 32'h3cb7;
        {rst, cfgIsa, cfgWide16, preempt, xferValid, xferWrite, xferMem, xferLast} = 8'h80;
        {xferBurst, xferLock, xferSize16, expBurst} = 4'h0;
        {xferAddr, xferBe, waitCnt, termSel, xferWdata} = '0;
        repeat (16) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        for (int k = 0; k < 12; k++) begin
            r         = rnd();
            cfgWide16 = r[16];
            cfgIsa    = r[17];
            len       = 1 + int'(r[19:18]);
            for (int j = 0; j < len; j++) xfer(j == 0, j == len - 1, r[20], r[21] & ~r[16]);
        end
        cfgIsa    = 1'b1;
        cfgWide16 = 1'b1;
        xfer(1'b1, 1'b0, 1'b0, 1'b0);
        preempt = 1'b1;
        wait_hi(3, 200);
        // two synchroniser flops are the only delay allowed before the size line lets go
        repeat (1) @(posedge ref_clk);
        #1;
        chk("master16_n on ack loss", 32'h1, {31'h0, master16_n});
        wait_hi(2, 64 * 12);
        chk("ctlOe after grant loss", 32'h0, {31'h0, ctlOe});
        preempt = 1'b0;
        give_verdict();
    end
endmodule
